// *** hdl/readout_consts.svh ***
// Purpose: named offsets, field positions, codes and sizes of the event readout formatter
// Assumes: included by bare name from the design file
// Notes: definitions only
`ifndef READOUT_CONSTS_SVH
`define READOUT_CONSTS_SVH
// register offsets
`define WIN_END        16'h07FF
`define FW_ADDR        16'h1000
`define GEO_ADDR       16'h1002
`define BS2_ADDR       16'h1032
`define BC2_ADDR       16'h1034
`define CRATE_ADDR     16'h103C
`define CTRL_BASE      16'h1000
`define CTRL_LAST      16'h10BF
`define ROM_BASE       16'h8000
// broadcast-writable halfwords, bit n = offset CTRL_BASE + 2n
`define BCAST_MAP      96'hFFFFFFFF_00340001_7EF10F78
// word type tags
`define TAG_HEAD       3'h2
`define TAG_DATA       3'h0
`define TAG_TRAILER    3'h4
`define TAG_NV         3'h6
`define NOT_VALID      32'h06000000
// field positions
`define GEO_LSB        27
`define TAG_LSB        24
`define CRATE_LSB      16
`define COUNT_LSB      8
`define CHAN_LSB_FULL  16
`define CHAN_LSB_HALF  17
`define BELOW_BIT      13
`define RANGE_BIT      12
// control bits
`define BS2_OVF_BIT    3
`define BS2_BELOW_BIT  4
// reset values and identity (revision value is arbitrary)
`define GEO_RESET      5'h1F
`define CRATE_RESET    8'h00
`define BS2_RESET      16'h0000
`define FW_REV         16'h0102
`define ROM_WORD       32'h00000000
// sizes
`define MEM_DEPTH      512
`define MEM_FREE       10'h200
`define EVT_MAX_WORDS  10'h022
`define CH_FULL        6'h20
`define CH_HALF        6'h10
`endif

// *** hdl/readout_pkg.sv ***
// Purpose: types of the event readout formatter
// Assumes: nothing
// Notes: state encoding left to the tool
package readout_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_HEAD, ST_TAIL} fmt_state_type;
endpackage

// *** hdl/event_buffer_readout_formatter.sv ***
// Purpose: packs conversion results into tagged 32-bit words in the multi-event store and serves register reads
// Assumes: all inputs synchronous to sys_clk; one register request per pulse of regRead or regWrite
// Notes: answers come one cycle after the request on regAck or regBusErr
`include "readout_consts.svh"
module event_buffer_readout_formatter
  import readout_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  input  wire logic          regRead,
  input  wire logic          regWrite,
  input  wire logic [15:0]   regAddr,
  input  wire logic [15:0]   regWData,
  input  wire logic          chainedRead,
  input  wire logic          broadcastWrite,
  input  wire logic          wide64,
  output logic      [63:0]   regRData,
  output logic               regAck,
  output logic               regBusErr,
  input  wire logic          convDone,
  input  wire logic [383:0]  convValue,
  input  wire logic [31:0]   rangeExceeded,
  input  wire logic [31:0]   belowThreshold,
  input  wire logic [31:0]   chanDisable,
  input  wire logic [23:0]   eventCounter,
  input  wire logic          auxSlotConnector,
  input  wire logic [4:0]    geoStrap,
  input  wire logic          halfChannels,
  output logic               dataReady,
  output logic               storeBusy
);

  // word builders for the header and trailer that the formatter stores
  function automatic logic [31:0] headWord(input logic [4:0] g, input logic [7:0] c, input logic [5:0] n);
    headWord = (32'(g) << `GEO_LSB) | (32'(`TAG_HEAD) << `TAG_LSB) | (32'(c) << `CRATE_LSB)
             | (32'(n) << `COUNT_LSB);
  endfunction

  function automatic logic [31:0] tailWord(input logic [4:0] g, input logic [23:0] e);
    tailWord = (32'(g) << `GEO_LSB) | (32'(`TAG_TRAILER) << `TAG_LSB) | 32'(e);
  endfunction

  // multi-event store and control state
  logic [31:0]   storeMem [0:`MEM_DEPTH-1];
  fmt_state_type state_r;
  fmt_state_type state_nxt;
  logic [8:0]    rdPtr_r;
  logic [8:0]    startPtr_r;
  logic [8:0]    wrPos_r;
  logic [9:0]    commitCnt_r;
  logic [5:0]    scanIdx_r;
  logic [5:0]    chanCnt_r;
  logic [383:0]  valLatch_r;
  logic [31:0]   keepLatch_r;
  logic [31:0]   belowLatch_r;
  logic [31:0]   rangeLatch_r;
  logic [23:0]   evtLatch_r;
  logic          halfLatch_r;
  logic [4:0]    geo_r;
  logic [7:0]    crate_r;
  logic [15:0]   bitSet2_r;
  logic          geoLoaded_r;
  logic [63:0]   regRData_r;
  logic          regAck_r;
  logic          regBusErr_r;
  logic          dataReady_r;
  logic          storeBusy_r;

  // channel order and per-channel word
  wire  [5:0]  chanCount  = halfLatch_r ? `CH_HALF : `CH_FULL;
  wire  [5:0]  halfSpan   = halfLatch_r ? (`CH_HALF >> 1) : (`CH_FULL >> 1);
  wire  [4:0]  scanChan   = 5'(scanIdx_r[0] ? halfSpan + (scanIdx_r >> 1) : (scanIdx_r >> 1));
  wire  [11:0] scanValue  = valLatch_r[12*scanChan +: 12];
  wire         scanKeep   = keepLatch_r[scanChan];
  wire  [4:0]  chanField  = halfLatch_r ? 5'(scanChan) : scanChan;
  wire  [31:0] chanBits   = halfLatch_r ? (32'(chanField) << `CHAN_LSB_HALF)
                                        : (32'(chanField) << `CHAN_LSB_FULL);
  wire  [31:0] dataWord   = (32'(geo_r) << `GEO_LSB) | (32'(`TAG_DATA) << `TAG_LSB) | chanBits
                          | (32'(belowLatch_r[scanChan]) << `BELOW_BIT)
                          | (32'(rangeLatch_r[scanChan]) << `RANGE_BIT)
                          | 32'(scanValue);
  wire         scanLast   = (scanIdx_r == chanCount - 6'h01);
  wire         roomOk     = (`MEM_FREE - commitCnt_r) >= `EVT_MAX_WORDS;

  // channels kept: disabled always skipped; overflow and under threshold unless enabled
  wire  [31:0] keepMask   = ~chanDisable
                          & (bitSet2_r[`BS2_OVF_BIT] ? 32'hFFFFFFFF : ~rangeExceeded)
                          & (bitSet2_r[`BS2_BELOW_BIT] ? 32'hFFFFFFFF : ~belowThreshold);

  // register decode
  wire         inWindow   = (regAddr <= `WIN_END);
  wire         inRom      = (regAddr >= `ROM_BASE);
  wire         inCtrl     = (regAddr >= `CTRL_BASE) && (regAddr <= `CTRL_LAST) && !regAddr[0];
  wire  [95:0] bcastMap   = `BCAST_MAP;
  wire  [6:0]  ctrlIdx    = 7'(regAddr[7:1]);
  wire         listedReg  = inCtrl && bcastMap[ctrlIdx];
  wire         geoWrOk    = (regAddr == `GEO_ADDR) && !auxSlotConnector;
  wire  [9:0]  popWant    = (wide64 && (commitCnt_r > 10'h001)) ? 10'h002 : 10'h001;
  wire  [9:0]  popCnt     = (commitCnt_r == 10'h000) ? 10'h000 : popWant;
  wire         bcastOk    = regWrite && listedReg && !wide64;
  wire         chainOk    = regRead && inWindow;
  wire         normRdOk   = regRead && (inWindow || inRom || (regAddr == `FW_ADDR) || (regAddr == `GEO_ADDR)
                          || (regAddr == `BS2_ADDR) || (regAddr == `CRATE_ADDR)) && !(wide64 && !inWindow);
  wire         normWrOk   = regWrite && !wide64 && (listedReg || geoWrOk);
  wire         reqOk      = broadcastWrite ? bcastOk : (chainedRead ? chainOk : (normRdOk || normWrOk));
  wire         wrTake     = regWrite && reqOk;
  wire         popTake    = regRead && reqOk && inWindow;
  wire  [9:0]  popNow     = popTake ? popCnt : 10'h000;
  wire  [8:0]  rdPtrNext  = rdPtr_r + 9'h001;
  wire  [31:0] wordA      = (commitCnt_r == 10'h000) ? `NOT_VALID : storeMem[rdPtr_r];
  wire  [31:0] wordB      = (commitCnt_r > 10'h001) ? storeMem[rdPtrNext] : `NOT_VALID;
  wire  [9:0]  evtWords   = 10'(chanCnt_r) + 10'h002;

  // read data mux; first word of a 64-bit pair sits in the upper half
  wire  [63:0] rdMux      = inWindow ? (wide64 ? {wordA, wordB} : {32'h0, wordA})
                          : inRom ? {32'h0, `ROM_WORD}
                          : (regAddr == `FW_ADDR) ? {48'h0, `FW_REV}
                          : (regAddr == `GEO_ADDR) ? {59'h0, geo_r}
                          : (regAddr == `BS2_ADDR) ? {48'h0, bitSet2_r}
                          : {56'h0, crate_r};

  // formatter sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (convDone && roomOk) state_nxt = ST_SCAN;
      ST_SCAN: if (scanLast) state_nxt = (chanCnt_r != 6'h00 || scanKeep) ? ST_HEAD : ST_IDLE;
      ST_HEAD: state_nxt = ST_TAIL;
      ST_TAIL: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) state_r <= ST_IDLE;
    else       state_r <= state_nxt;
  end

  // event capture and scan counters
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scanIdx_r    <= 6'h00;
      chanCnt_r    <= 6'h00;
      valLatch_r   <= '0;
      keepLatch_r  <= 32'h0;
      belowLatch_r <= 32'h0;
      rangeLatch_r <= 32'h0;
      evtLatch_r   <= 24'h0;
      halfLatch_r  <= 1'b0;
      startPtr_r   <= 9'h000;
      wrPos_r      <= 9'h000;
    end else if (state_r == ST_IDLE && state_nxt == ST_SCAN) begin
      scanIdx_r    <= 6'h00;
      chanCnt_r    <= 6'h00;
      valLatch_r   <= convValue;
      keepLatch_r  <= keepMask;
      belowLatch_r <= belowThreshold;
      rangeLatch_r <= rangeExceeded;
      evtLatch_r   <= eventCounter;
      halfLatch_r  <= halfChannels;
      wrPos_r      <= startPtr_r + 9'h001;   // header slot reserved first
    end else if (state_r == ST_SCAN) begin
      scanIdx_r <= scanIdx_r + 6'h01;
      if (scanKeep) begin
        chanCnt_r <= chanCnt_r + 6'h01;
        wrPos_r   <= wrPos_r + 9'h001;
      end
    end else if (state_r == ST_TAIL) begin
      startPtr_r <= wrPos_r + 9'h001;         // next event takes the next slot
    end
  end

  // store writes: data during scan, header into reserved slot, trailer last
  always_ff @(posedge sys_clk) begin
    if (state_r == ST_SCAN && scanKeep) storeMem[wrPos_r] <= dataWord;
    if (state_r == ST_HEAD) storeMem[startPtr_r] <= headWord(geo_r, crate_r, chanCnt_r);
    if (state_r == ST_TAIL) storeMem[wrPos_r] <= tailWord(geo_r, evtLatch_r);
  end

  // committed word count and read pointer; a whole event becomes visible at once
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      commitCnt_r <= 10'h000;
      rdPtr_r     <= 9'h000;
    end else begin
      commitCnt_r <= commitCnt_r + ((state_r == ST_TAIL) ? evtWords : 10'h000) - popNow;
      rdPtr_r     <= rdPtr_r + 9'(popNow);
    end
  end

  // slot position captured from geoStrap after reset release when aux connector is present; writable only without it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      geo_r       <= `GEO_RESET;
      geoLoaded_r <= 1'b0;
      crate_r     <= `CRATE_RESET;
      bitSet2_r   <= `BS2_RESET;
    end else begin
      geoLoaded_r <= 1'b1;
      if (!geoLoaded_r && auxSlotConnector) geo_r <= geoStrap;
      else if (wrTake && geoWrOk && !broadcastWrite) geo_r <= regWData[4:0];
      if (wrTake && regAddr == `CRATE_ADDR) crate_r <= regWData[7:0];
      if (wrTake && regAddr == `BS2_ADDR) bitSet2_r <= bitSet2_r | regWData;
      else if (wrTake && regAddr == `BC2_ADDR) bitSet2_r <= bitSet2_r & ~regWData;
    end
  end

  // bus answer and status outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      regRData_r  <= 64'h0;
      regAck_r    <= 1'b0;
      regBusErr_r <= 1'b0;
      dataReady_r <= 1'b0;
      storeBusy_r <= 1'b0;
    end else begin
      regAck_r    <= (regRead || regWrite) && reqOk;
      regBusErr_r <= (regRead || regWrite) && !reqOk;
      if (regRead && reqOk) regRData_r <= rdMux;
      dataReady_r <= (commitCnt_r + ((state_r == ST_TAIL) ? evtWords : 10'h000) - popNow) != 10'h000;
      storeBusy_r <= (state_nxt != ST_IDLE) || !roomOk;
    end
  end

  assign regRData  = regRData_r;
  assign regAck    = regAck_r;
  assign regBusErr = regBusErr_r;
  assign dataReady = dataReady_r;
  assign storeBusy = storeBusy_r;

  // checks
  sequence s_bcastRead;
    broadcastWrite && regRead;
  endsequence
  sequence s_eventEnd;
    state_r == ST_HEAD ##1 state_r == ST_TAIL;
  endsequence

  property p_emptyRead;
    @(posedge sys_clk) disable iff (!nrst)
      regRead && inWindow && reqOk && !wide64 && commitCnt_r == 10'h000 |=> regRData == {32'h0, `NOT_VALID};
  endproperty
  a_emptyRead: assert property (p_emptyRead) else $error("empty read not flagged");

  property p_chainDecode;
    @(posedge sys_clk) disable iff (!nrst)
      chainedRead && !broadcastWrite && (regRead || regWrite) && !(regRead && inWindow) |=> regBusErr && !regAck;
  endproperty
  a_chainDecode: assert property (p_chainDecode) else $error("chained access outside window answered");

  property p_bcastNoRead;
    @(posedge sys_clk) disable iff (!nrst) s_bcastRead |=> regBusErr;
  endproperty
  a_bcastNoRead: assert property (p_bcastNoRead) else $error("broadcast read accepted");

  property p_fwRev;
    @(posedge sys_clk) disable iff (!nrst)
      regRead && !chainedRead && !broadcastWrite && !wide64 && regAddr == `FW_ADDR |=> regRData == {48'h0, `FW_REV};
  endproperty
  a_fwRev: assert property (p_fwRev) else $error("revision read wrong");

  property p_romDecode;
    @(posedge sys_clk) disable iff (!nrst)
      regRead && !chainedRead && !broadcastWrite && !wide64 && inRom |=> regAck;
  endproperty
  a_romDecode: assert property (p_romDecode) else $error("ROM region not decoded");

  property p_commit;
    @(posedge sys_clk) disable iff (!nrst)
      s_eventEnd |=> commitCnt_r == $past(commitCnt_r) + 10'(chanCnt_r) + 10'h002 - $past(popNow);
  endproperty
  a_commit: assert property (p_commit) else $error("event word count wrong");

  property p_noEmptyEvent;
    @(posedge sys_clk) disable iff (!nrst) state_r == ST_HEAD |-> chanCnt_r != 6'h00;
  endproperty
  a_noEmptyEvent: assert property (p_noEmptyEvent) else $error("empty event stored");

  property p_dataTags;
    @(posedge sys_clk) disable iff (!nrst)
      state_r == ST_SCAN |-> dataWord[31:24] == {geo_r, `TAG_DATA} && dataWord[15:14] == 2'h0;
  endproperty
  a_dataTags: assert property (p_dataTags) else $error("datum tag or slot wrong");

  property p_order;
    @(posedge sys_clk) disable iff (!nrst)
      state_r == ST_SCAN && !halfLatch_r && scanIdx_r == 6'h01 |-> scanChan == 5'h10;
  endproperty
  a_order: assert property (p_order) else $error("interleave order wrong");

  property p_skip;
    @(posedge sys_clk) disable iff (!nrst)
      state_r == ST_SCAN && !scanKeep |=> chanCnt_r == $past(chanCnt_r);
  endproperty
  a_skip: assert property (p_skip) else $error("skipped channel counted");

  property p_wideEmpty;
    @(posedge sys_clk) disable iff (!nrst)
      regRead && inWindow && reqOk && wide64 && commitCnt_r == 10'h000 |=> regRData == {2{`NOT_VALID}};
  endproperty
  a_wideEmpty: assert property (p_wideEmpty) else $error("empty 64-bit read not flagged in both halves");

  property p_headWord;
    @(posedge sys_clk) disable iff (!nrst)
      state_r == ST_HEAD |=> storeMem[$past(startPtr_r)]
                             == {$past(geo_r), `TAG_HEAD, $past(crate_r), 2'h0, $past(chanCnt_r), 8'h00};
  endproperty
  a_headWord: assert property (p_headWord) else $error("stored header word wrong");

  property p_tailWord;
    @(posedge sys_clk) disable iff (!nrst)
      s_eventEnd |=> storeMem[$past(wrPos_r)] == {$past(geo_r), `TAG_TRAILER, $past(evtLatch_r)};
  endproperty
  a_tailWord: assert property (p_tailWord) else $error("stored trailer word wrong");

  property p_geoLocked;
    @(posedge sys_clk) disable iff (!nrst)
      regWrite && auxSlotConnector && regAddr == `GEO_ADDR |=> regBusErr && geo_r == $past(geo_r);
  endproperty
  a_geoLocked: assert property (p_geoLocked) else $error("slot position written despite strap");

endmodule // event_buffer_readout_formatter

// *** test/vme_read_master.sv ***
// Purpose: bus master model issuing register reads and writes to the formatter
// Assumes: a request is taken at a rising edge and answered one cycle later
// Notes: released address and data lines show their inverse so a stale value is never trusted
module vme_read_master (
  input  wire logic        sys_clk,
  input  wire logic [63:0] regRData,
  input  wire logic        regAck,
  input  wire logic        regBusErr,
  output logic             regRead,
  output logic             regWrite,
  output logic      [15:0] regAddr,
  output logic      [15:0] regWData,
  output logic             wide64
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet lines at time zero
  initial begin
    regRead = 1'b0;
    regWrite = 1'b0;
    regAddr = 16'h0000;
    regWData = 16'h0000;
    wide64 = 1'b0;
  end
  // one access: request at an edge, taken at the next, answer read in that cycle
  task automatic access(input logic wr, input logic [15:0] a, d, input logic w64,
                        output logic ack, err, output logic [63:0] q);
    @(posedge sys_clk);
    regRead <= !wr;
    regWrite <= wr;
    regAddr <= a;
    regWData <= d;
    wide64 <= w64;
    @(posedge sys_clk);
    regRead <= 1'b0;
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWData <= ~d;
    wide64 <= 1'b0;
    #1;
    ack = regAck;
    err = regBusErr;
    q = regRData;
  endtask
endmodule // vme_read_master

// *** test/testbench.sv ***
// Purpose: self-checking bench of the event readout formatter
// Assumes: 25 MHz clock, reset held 16 cycles, slot strap absent until a mid-run reset
// Notes: expected words are built here from flags and values sent
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic           sys_clk = 1'b0;
  logic           nrst, chainedRead, broadcastWrite, convDone, auxSlotConnector, halfChannels;
  logic           regRead, regWrite, wide64, regAck, regBusErr, dataReady, storeBusy;
  logic [15:0]    regAddr, regWData;
  logic [63:0]    regRData;
  logic [383:0]   convValue;
  logic [31:0]    rangeExceeded, belowThreshold, chanDisable;
  logic [23:0]    eventCounter;
  logic [4:0]     geoStrap, geo, bs2;
  logic [7:0]     crate;
  logic [31:0]    expq[$];
  logic [63:0]    q;
  int             failures = 0;
  int             testsRun = 0;
  always #20 sys_clk = ~sys_clk;
  event_buffer_readout_formatter event_buffer_readout_formatter_i (.sys_clk(sys_clk), .nrst(nrst),
    .regRead(regRead), .regWrite(regWrite), .regAddr(regAddr), .regWData(regWData),
    .chainedRead(chainedRead), .broadcastWrite(broadcastWrite), .wide64(wide64),
    .regRData(regRData), .regAck(regAck), .regBusErr(regBusErr), .convDone(convDone),
    .convValue(convValue), .rangeExceeded(rangeExceeded), .belowThreshold(belowThreshold),
    .chanDisable(chanDisable), .eventCounter(eventCounter), .auxSlotConnector(auxSlotConnector),
    .geoStrap(geoStrap), .halfChannels(halfChannels), .dataReady(dataReady), .storeBusy(storeBusy));
  vme_read_master vme_read_master_i (.sys_clk(sys_clk), .regRData(regRData), .regAck(regAck),
    .regBusErr(regBusErr), .regRead(regRead), .regWrite(regWrite), .regAddr(regAddr),
    .regWData(regWData), .wide64(wide64));
  // verdict and end of run
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", testsRun, failures);
    if (failures == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, e);
    testsRun++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // access with expected answer kind
  task automatic acc(input logic wr, input logic [15:0] a, d, input logic w64, input logic eerr);
    logic ak, er;
    vme_read_master_i.access(wr, a, d, w64, ak, er, q);
    chk({62'h0, ak, er}, {62'h0, !eerr, eerr});
  endtask
  task automatic rd(input logic [15:0] a, input logic [63:0] e);
    acc(1'b0, a, 16'h0000, 1'b0, 1'b0);
    chk(q, e);
  endtask
  function automatic logic [11:0] val(input int c);
    return 12'(c * 131 + 7);
  endfunction
  // one conversion; expected words queued as header, kept data, trailer
  task automatic evt(input logic hf, input logic [31:0] ov, un, dis, input logic [23:0] cnt);
    int n, c, k;
    logic [4:0] ch;
    logic [31:0] d[$];
    n = hf ? 16 : 32;
    for (k = 0; k < n; k++) begin
      c = (k % 2 == 0) ? k / 2 : k / 2 + n / 2;
      ch = 5'(c);
      if (!dis[c] && (!ov[c] || bs2[3]) && (!un[c] || bs2[4])) begin
        d.push_back({geo, 6'h00, hf ? {ch[3:0], 1'b0} : ch, 2'h0, un[c], ov[c], val(c)});
      end
    end
    if (d.size() > 0) begin
      expq.push_back({geo, 3'h2, crate, 2'h0, 6'(d.size()), 8'h00});
      foreach (d[i]) expq.push_back(d[i]);
      expq.push_back({geo, 3'h4, cnt});
    end
    @(posedge sys_clk);
    for (k = 0; k < 32; k++) convValue[12 * k +: 12] <= val(k);
    convDone <= 1'b1;
    halfChannels <= hf;
    rangeExceeded <= ov;
    belowThreshold <= un;
    chanDisable <= dis;
    eventCounter <= cnt;
    @(posedge sys_clk);
    convDone <= 1'b0;
    #1;
    chk({63'h0, storeBusy}, 64'h1);
    for (k = 0; k < 100 && storeBusy === 1'b1; k++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({63'h0, storeBusy}, 64'h0);
    chk({63'h0, dataReady}, {63'h0, expq.size() > 0});
  endtask
  // empty the store in order, then expect the not-valid word
  task automatic drain(input logic w64);
    logic [31:0] hi, lo;
    int i;
    for (i = 0; expq.size() > 0; i++) begin
      hi = expq.pop_front();
      lo = (w64 && expq.size() > 0) ? expq.pop_front() : 32'h06000000;
      acc(1'b0, 16'(4 * (i % 512)), 16'h0000, w64, 1'b0);
      chk(q, w64 ? {hi, lo} : {32'h0, hi});
    end
    rd(16'h07FC, 64'h06000000);
    chk({63'h0, dataReady}, 64'h0);
  endtask
  // main sequence
  initial begin
    {nrst, chainedRead, broadcastWrite, convDone, auxSlotConnector, halfChannels} = 6'h00;
    {convValue, rangeExceeded, belowThreshold, chanDisable, eventCounter} = '0;
    geoStrap = 5'h09;
    geo = 5'h1F;
    crate = 8'h00;
    bs2 = 5'h00;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd(16'h0000, 64'h06000000);
    acc(1'b0, 16'h0004, 16'h0000, 1'b1, 1'b0);
    chk(q, {2{32'h06000000}});
    rd(16'h1000, 64'h0102);
    rd(16'h8000, 64'h0);
    rd(16'hFFFE, 64'h0);
    acc(1'b1, 16'h1000, 16'h1234, 1'b0, 1'b1);
    acc(1'b1, 16'h0000, 16'h1234, 1'b0, 1'b1);
    acc(1'b0, 16'h1000, 16'h0000, 1'b1, 1'b1);
    rd(16'h1002, 64'h1F);
    acc(1'b1, 16'h1002, 16'h000B, 1'b0, 1'b0);
    geo = 5'h0B;
    acc(1'b1, 16'h103C, 16'h00A5, 1'b0, 1'b0);
    crate = 8'hA5;
    evt(1'b0, 32'h00010004, 32'h00000102, 32'h80000020, 24'h123456);
    drain(1'b0);
    acc(1'b1, 16'h1032, 16'h0018, 1'b0, 1'b0);
    bs2 = 5'h18;
    evt(1'b0, 32'h00010004, 32'h00000102, 32'h80000020, 24'hFFFFFF);
    drain(1'b0);
    acc(1'b1, 16'h1034, 16'h0008, 1'b0, 1'b0);
    bs2 = 5'h10;
    rd(16'h1032, 64'h10);
    evt(1'b0, 32'hFFFF0000, 32'h0, 32'h0000FFFF, 24'h000001);
    evt(1'b1, 32'h0, 32'h0, 32'h00000010, 24'h000777);
    evt(1'b0, 32'h0, 32'h0, 32'h7FFFFFFE, 24'h000778);
    @(posedge sys_clk);
    chainedRead <= 1'b1;
    acc(1'b0, 16'h1000, 16'h0000, 1'b0, 1'b1);
    acc(1'b1, 16'h0000, 16'h0000, 1'b0, 1'b1);
    drain(1'b1);
    @(posedge sys_clk);
    chainedRead <= 1'b0;
    broadcastWrite <= 1'b1;
    acc(1'b1, 16'h1006, 16'h0000, 1'b0, 1'b0);
    acc(1'b1, 16'h10BE, 16'h0000, 1'b0, 1'b0);
    acc(1'b1, 16'h103C, 16'h005A, 1'b0, 1'b0);
    acc(1'b1, 16'h1002, 16'h0001, 1'b0, 1'b1);
    acc(1'b1, 16'h1030, 16'h0000, 1'b0, 1'b1);
    acc(1'b0, 16'h1006, 16'h0000, 1'b0, 1'b1);
    acc(1'b0, 16'h0000, 16'h0000, 1'b0, 1'b1);
    @(posedge sys_clk);
    broadcastWrite <= 1'b0;
    rd(16'h103C, 64'h5A);
    // leave an event stored, then reset mid-run with the slot strap present
    evt(1'b0, 32'h0, 32'h0, 32'hFFFFFFFE, 24'h000100);
    @(posedge sys_clk);
    auxSlotConnector <= 1'b1;
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk({62'h0, dataReady, storeBusy}, 64'h0);
    nrst <= 1'b1;
    expq.delete();
    repeat (2) @(posedge sys_clk);
    rd(16'h1002, 64'h09);
    acc(1'b1, 16'h1002, 16'h0003, 1'b0, 1'b1);
    rd(16'h1002, 64'h09);
    rd(16'h103C, 64'h0);
    rd(16'h1032, 64'h0);
    rd(16'h0000, 64'h06000000);
    end_of_test();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    end_of_test();
  end
endmodule // testbench
